/* File: hdl/dcv_pkg.sv */
// Package: offsets, fields, reset values and types of the channel 2 output/volume registers
package dcv_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_NEG_CFG = 8'h6d;
  localparam logic [7:0] OFS_A_VOL = 8'h6e;
  localparam logic [7:0] OFS_A_FGAIN = 8'h6f;
  localparam logic [7:0] OFS_B_VOL = 8'h70;
  localparam logic [7:0] RST_NEG_CFG = 8'h20;
  localparam logic [7:0] RST_A_VOL = 8'hc9;
  localparam logic [7:0] RST_A_FGAIN = 8'h80;
  localparam logic [7:0] RST_B_VOL = 8'hc9;
  // Writable bits of each register; reserved bits are zero here
  localparam logic [7:0] WMASK_NEG_CFG = 8'hfb;
  localparam logic [7:0] WMASK_A_FGAIN = 8'hf0;
  localparam logic [7:0] WMASK_VOL = 8'hff;
  localparam int DRV_LSB = 6;
  localparam int LVL_LSB = 3;
  localparam int RSVD_BIT = 2;
  localparam int FS_BIT = 1;
  localparam int CM_BIT = 0;
  localparam int FG_LSB = 4;
  localparam logic [7:0] VOL_MUTE = 8'h00;
  localparam logic [7:0] VOL_UNITY = 8'hc9;
  localparam logic [3:0] FG_ZERO = 4'h8;
  localparam logic [2:0] LVL_MIN_LEGAL = 3'h4;

  typedef enum logic [1:0] {
    DCV_DRV_LINE,
    DCV_DRV_HEADPHONE,
    DCV_DRV_FOUR_OHM,
    DCV_DRV_RECEIVER
  } dcv_drive_t;

  // Decoded settings handed to the analog and DSP sides
  typedef struct packed {
    dcv_drive_t neg_out_driver_type;
    logic [2:0] neg_out_level;
    logic ch2_full_scale_sel;
    logic ch2_common_mode_tolerance;
    logic [7:0] path_a_digital_volume;
    logic [3:0] path_a_fine_gain;
    logic [7:0] path_b_digital_volume;
  } dcv_cfg_t;

  // Volume status for one path
  typedef struct packed {
    logic mute;
    logic unity;
    logic boost;
  } dcv_vol_stat_t;
endpackage

/* File: hdl/dcv_regs.sv */
// Register slice for DAC channel 2 negative output, full scale and path volumes
// How it works
// [R1] Path A volume code zero mutes; one is -100 dB; each step adds 0.5 dB.
// [R2] Code 201 is unity gain; above it boosts to +27 dB at 255.
// [R3] Path A volume is bits 7..0 of its own register, resetting to 0xc9.
// [R4] Path B has its own volume register, same encoding, reset 0xc9.
// [R5] Path A fine gain sits in bits 7..4, 0.1 dB per code.
// [R6] Path A fine gain resets to code eight, meaning 0 dB.
// [R7] Low four bits of the fine gain register read zero; host writes zero.
// [R8] Bit 2 of the output configuration register reads zero; host writes zero.
// [R9] Bits 7..6 pick negative output driver type, reset line out.
// [R10] Bits 5..3 set negative output level, reset 4; codes 0..3 unused.
// [R11] Bit 1 selects full scale: zero 10 Vrms, one 5 Vrms.
// [R12] Bit 0 selects common-mode tolerance: zero AC limited, one rail to rail.
// [R13] Output configuration register lives at 0x6d and resets to 0x20.
// [R14] Writes to reserved read-only bits are ignored; they keep reading reset value.
`timescale 1ns/100ps
`default_nettype none
module dcv_regs
  import dcv_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata,
  output logic rvalid,
  output logic addr_hit,
  output logic lvl_illegal,
  output dcv_cfg_t cfg,
  output dcv_vol_stat_t stat_a,
  output dcv_vol_stat_t stat_b
);
  logic [7:0] neg_cfg_r;
  logic [7:0] a_vol_r;
  logic [7:0] a_fg_r;
  logic [7:0] b_vol_r;
  logic [7:0] rd_nxt;
  logic hit;

  always_comb begin
    hit = 1'b1;
    unique case (addr)
      OFS_NEG_CFG: rd_nxt = neg_cfg_r;
      OFS_A_VOL: rd_nxt = a_vol_r;
      OFS_A_FGAIN: rd_nxt = a_fg_r;
      OFS_B_VOL: rd_nxt = b_vol_r;
      default: begin
        rd_nxt = 8'h00;
        hit = 1'b0;
      end
    endcase
  end
  assign addr_hit = hit;

  // Reserved bits are masked to zero on every write, so they cannot drift from reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      neg_cfg_r <= RST_NEG_CFG; // see [R13]
    end else if (wr_en && addr == OFS_NEG_CFG) begin
      neg_cfg_r <= wdata & WMASK_NEG_CFG; // see [R8] see [R14]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_vol_r <= RST_A_VOL; // see [R3]
    end else if (wr_en && addr == OFS_A_VOL) begin
      a_vol_r <= wdata & WMASK_VOL; // see [R3]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_fg_r <= RST_A_FGAIN; // see [R6]
    end else if (wr_en && addr == OFS_A_FGAIN) begin
      a_fg_r <= wdata & WMASK_A_FGAIN; // see [R5] see [R7] see [R14]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      b_vol_r <= RST_B_VOL; // see [R4]
    end else if (wr_en && addr == OFS_B_VOL) begin
      b_vol_r <= wdata & WMASK_VOL; // see [R4]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_en;
      if (rd_en) begin
        rdata <= rd_nxt;
      end
    end
  end

  always_comb begin
    cfg.neg_out_driver_type = dcv_drive_t'(neg_cfg_r[DRV_LSB +: 2]); // see [R9]
    cfg.neg_out_level = neg_cfg_r[LVL_LSB +: 3]; // see [R10]
    cfg.ch2_full_scale_sel = neg_cfg_r[FS_BIT]; // see [R11]
    cfg.ch2_common_mode_tolerance = neg_cfg_r[CM_BIT]; // see [R12]
    cfg.path_a_digital_volume = a_vol_r; // see [R1]
    cfg.path_a_fine_gain = a_fg_r[FG_LSB +: 4]; // see [R5]
    cfg.path_b_digital_volume = b_vol_r; // see [R4]
  end

  // Flags a host breaking the level contract; hardware still passes the code on
  assign lvl_illegal = (cfg.neg_out_level < LVL_MIN_LEGAL); // see [R10]

  dcv_vol_decode u_dec_a (
    .clk(clk),
    .rst(rst),
    .code(a_vol_r),
    .stat(stat_a)
  );

  dcv_vol_decode u_dec_b (
    .clk(clk),
    .rst(rst),
    .code(b_vol_r),
    .stat(stat_b)
  );

  property p_rsvd_neg;
    @(posedge clk) disable iff (rst) neg_cfg_r[RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_neg: assert property (p_rsvd_neg) else $error("reserved bit 2 set"); // see [R8]

  property p_rsvd_fg;
    @(posedge clk) disable iff (rst) a_fg_r[3:0] == 4'h0;
  endproperty
  a_rsvd_fg: assert property (p_rsvd_fg) else $error("fine gain low bits set"); // see [R7]

  property p_rd_fg;
    @(posedge clk) disable iff (rst) rd_en && addr == OFS_A_FGAIN |=> rdata[3:0] == 4'h0;
  endproperty
  a_rd_fg: assert property (p_rd_fg) else $error("fine gain read not zero low"); // see [R14]

  property p_wr_avol;
    @(posedge clk) disable iff (rst)
      wr_en && addr == OFS_A_VOL |=> a_vol_r == $past(wdata);
  endproperty
  a_wr_avol: assert property (p_wr_avol) else $error("path A volume not written"); // see [R3]

  property p_wr_bvol;
    @(posedge clk) disable iff (rst)
      wr_en && addr == OFS_B_VOL |=> b_vol_r == $past(wdata);
  endproperty
  a_wr_bvol: assert property (p_wr_bvol) else $error("path B volume not written"); // see [R4]

  property p_wr_neg;
    @(posedge clk) disable iff (rst)
      wr_en && addr == OFS_NEG_CFG |=> neg_cfg_r == ($past(wdata) & WMASK_NEG_CFG);
  endproperty
  a_wr_neg: assert property (p_wr_neg) else $error("config write wrong"); // see [R13]

  property p_mute;
    @(posedge clk) disable iff (rst)
      a_vol_r == 8'h00 ##1 a_vol_r == 8'h00 |-> stat_a.mute;
  endproperty
  a_mute: assert property (p_mute) else $error("path A not muted at code 0"); // see [R1]

  property p_unity;
    @(posedge clk) disable iff (rst)
      b_vol_r == 8'hc9 ##1 b_vol_r == 8'hc9 |-> stat_b.unity && !stat_b.boost;
  endproperty
  a_unity: assert property (p_unity) else $error("path B not unity at 201"); // see [R2]

  property p_fields;
    @(posedge clk) disable iff (rst)
      cfg.ch2_full_scale_sel == neg_cfg_r[1] && cfg.path_a_fine_gain == a_fg_r[7:4];
  endproperty
  a_fields: assert property (p_fields) else $error("field map wrong"); // see [R11]

  // Sampled values at the release edge still show the reset load
  property p_rst_neg;
    @(posedge clk) $fell(rst) |-> neg_cfg_r == RST_NEG_CFG;
  endproperty
  a_rst_neg: assert property (p_rst_neg) else $error("config reset value wrong"); // see [R13]

  property p_rst_avol;
    @(posedge clk) $fell(rst) |-> a_vol_r == RST_A_VOL;
  endproperty
  a_rst_avol: assert property (p_rst_avol) else $error("path A volume reset wrong"); // see [R3]

  property p_rst_fg;
    @(posedge clk) $fell(rst) |-> a_fg_r == RST_A_FGAIN;
  endproperty
  a_rst_fg: assert property (p_rst_fg) else $error("fine gain reset wrong"); // see [R6]

  property p_rst_bvol;
    @(posedge clk) $fell(rst) |-> b_vol_r == RST_B_VOL;
  endproperty
  a_rst_bvol: assert property (p_rst_bvol) else $error("path B volume reset wrong"); // see [R4]

  property p_rd_neg;
    @(posedge clk) disable iff (rst) rd_en && addr == OFS_NEG_CFG |=> rdata[RSVD_BIT] == 1'b0;
  endproperty
  a_rd_neg: assert property (p_rd_neg) else $error("config read reserved bit set"); // see [R8]

  property p_unmapped;
    @(posedge clk) disable iff (rst) rd_en && !addr_hit |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // see [R13]

  property p_boost;
    @(posedge clk) disable iff (rst)
      a_vol_r > VOL_UNITY ##1 a_vol_r > VOL_UNITY |-> stat_a.boost && !stat_a.unity;
  endproperty
  a_boost: assert property (p_boost) else $error("path A not boosting above 201"); // see [R2]

  property p_mute_b;
    @(posedge clk) disable iff (rst)
      b_vol_r == VOL_MUTE ##1 b_vol_r == VOL_MUTE |-> stat_b.mute && !stat_b.unity;
  endproperty
  a_mute_b: assert property (p_mute_b) else $error("path B not muted at code 0"); // see [R4]
endmodule
`default_nettype wire

/* File: hdl/dcv_vol_decode.sv */
// Volume code classifier for one digital path
`timescale 1ns/100ps
`default_nettype none
module dcv_vol_decode
  import dcv_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] code,
  output dcv_vol_stat_t stat
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat <= '{mute: 1'b0, unity: 1'b1, boost: 1'b0};
    end else begin
      stat.mute <= (code == VOL_MUTE); // see [R1]
      stat.unity <= (code == VOL_UNITY); // see [R2]
      stat.boost <= (code > VOL_UNITY); // see [R2]
    end
  end
endmodule
`default_nettype wire

/* File: verif/test_dcv_regs.sv */
// Self-checking bench for the channel 2 output and volume register slice
`timescale 1ns/100ps
`default_nettype none
module test_dcv_regs;
  import dcv_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dcv_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic addr_hit;
  logic lvl_illegal;
  dcv_cfg_t cfg;
  dcv_vol_stat_t stat_a;
  dcv_vol_stat_t stat_b;
  int failures = 0;
  int checked = 0;
  // Address, write data, expected readback
  dcv_row_t rows[13] = '{'{8'h6d, 8'hff, 8'hfb}, '{8'h6d, 8'h24, 8'h20}, '{8'h6d, 8'h48, 8'h48},
    '{8'h6d, 8'hab, 8'hab}, '{8'h6d, 8'he4, 8'he0}, '{8'h6e, 8'h00, 8'h00},
    '{8'h6e, 8'h5a, 8'h5a}, '{8'h6f, 8'hff, 8'hf0}, '{8'h6f, 8'h0f, 8'h00},
    '{8'h6f, 8'h30, 8'h30}, '{8'h70, 8'ha5, 8'ha5}, '{8'h71, 8'h55, 8'h00},
    '{8'h6c, 8'haa, 8'h00}};
  // Volume code boundaries and their {mute, unity, boost}
  logic [7:0] vcode[6] = '{8'h00, 8'h01, 8'hc8, 8'hc9, 8'hca, 8'hff};
  logic [2:0] vstat[6] = '{3'b100, 3'b000, 3'b000, 3'b010, 3'b001, 3'b001};

  dcv_regs dcv_regs_i (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .addr_hit(addr_hit),
    .lvl_illegal(lvl_illegal), .cfg(cfg), .stat_a(stat_a), .stat_b(stat_b));

  always #5 clk = ~clk;

  task automatic print_verdict;
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chks(input dcv_vol_stat_t got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: status %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    chk8({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    #100000;
    failures++;
    print_verdict;
  end

  initial begin
    logic [7:0] r;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    rd(OFS_NEG_CFG, r);
    chk8(r, 8'h20);
    rd(OFS_A_VOL, r);
    chk8(r, 8'hc9);
    rd(OFS_A_FGAIN, r);
    chk8(r, 8'h80);
    rd(OFS_B_VOL, r);
    chk8(r, 8'hc9);
    chks(stat_a, 3'b010);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      chk8(r, rows[i].e);
      chk8({7'h00, addr_hit}, {7'h00, rows[i].a inside {[OFS_NEG_CFG:OFS_B_VOL]}});
      if (rows[i].a == 8'h6d) begin
        chk8({6'h00, cfg.neg_out_driver_type}, {6'h00, rows[i].d[7:6]});
        chk8({5'h00, cfg.neg_out_level}, {5'h00, rows[i].d[5:3]});
        chk8({7'h00, cfg.ch2_full_scale_sel}, {7'h00, rows[i].d[1]});
        chk8({7'h00, cfg.ch2_common_mode_tolerance}, {7'h00, rows[i].d[0]});
        chk8({7'h00, lvl_illegal}, {7'h00, rows[i].d[5:3] < 3'h4});
      end
      if (rows[i].a == 8'h6f) begin
        chk8({4'h0, cfg.path_a_fine_gain}, {4'h0, rows[i].d[7:4]});
      end
    end
    foreach (vcode[i]) begin
      wr(OFS_A_VOL, vcode[i]);
      wr(OFS_B_VOL, vcode[i]);
      chk8(cfg.path_a_digital_volume, vcode[i]);
      chk8(cfg.path_b_digital_volume, vcode[i]);
      // Status flops lag the register by one edge
      @(posedge clk);
      #1;
      chks(stat_a, vstat[i]);
      chks(stat_b, vstat[i]);
    end
    // Write and read in one cycle: the read returns the old value
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    rd_en = 1'b1;
    addr = OFS_B_VOL;
    wdata = 8'h33;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    chk8(rdata, 8'hff);
    rd(OFS_B_VOL, r);
    chk8(r, 8'h33);
    // Second reset in mid-run restores the defaults
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    rd(OFS_A_FGAIN, r);
    chk8(r, 8'h80);
    rd(OFS_NEG_CFG, r);
    chk8(r, 8'h20);
    rd(OFS_B_VOL, r);
    chk8(r, 8'hc9);
    print_verdict;
  end
endmodule
`default_nettype wire
